// ==== design/dual_adc_mode_sequencer.sv ====
// Purpose: Mode decode, reset and sequencing of two sigma-delta converters.
// Assumes: Core bus and converter done pulses run on mclk_i.
// Notes: Converter controls lag the registers by one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"

module dual_adc_mode_sequencer
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire adc_seq_pkg::sfr_bus_t sfr_i,
  input wire adc_seq_pkg::conv_done_t done_i,
  output logic [7:0] sfr_rdata_o,
  output adc_seq_pkg::conv_ctrl_t pri_ctrl_o,
  output adc_seq_pkg::conv_ctrl_t aux_ctrl_o,
  output logic [7:0] filter_rate_o
);
  import adc_seq_pkg::*;

  logic [7:0] mode_reg;
  logic [7:0] pri_cfg;
  logic [7:0] aux_cfg;
  logic [7:0] filter_rate;
  logic primary_ready_flag, auxiliary_ready_flag, auxiliary_error_flag;
  seq_state_t state, next_state;
  logic restart, aux_restart;
  logic pend_pri, pend_aux;
  logic aux_seen;
  logic [1:0] align_cnt;

  logic wr_mode, wr_pri_cfg, wr_aux_cfg, wr_status, wr_filter;
  mode_t md, new_md;
  logic pri_en, aux_en, new_pri_en, new_aux_en;
  logic md_changed;
  logic pri_rise, aux_rise;
  logic aux_only_mode_wr;
  logic both_reset_req;
  logic aux_reset_req;
  logic running, is_cal, pri_running;
  logic pri_acc, aux_acc;
  logic aux_on_temp;
  logic seq_finish;
  logic cal_code_wr;
  input_src_t cal_src;

  // Write strobes from the register bus
  always_comb
  begin
    wr_mode = 1'b0;
    wr_pri_cfg = 1'b0;
    wr_aux_cfg = 1'b0;
    wr_status = 1'b0;
    wr_filter = 1'b0;
    if (!sfr_i.wr)
      wr_mode = 1'b0;
    else if (sfr_i.addr == `MODE_ADDR)
      wr_mode = 1'b1;
    else if (sfr_i.addr == `PRI_CFG_ADDR)
      wr_pri_cfg = 1'b1;
    else if (sfr_i.addr == `AUX_CFG_ADDR)
      wr_aux_cfg = 1'b1;
    else if (sfr_i.addr == `STATUS_ADDR)
      wr_status = 1'b1;
    else if (sfr_i.addr == `FILTER_ADDR)
      wr_filter = 1'b1;
  end

  // Reset decisions
  assign md = mode_t'(mode_reg[`MODE_MD_MSB:`MODE_MD_LSB]);
  assign new_md = mode_t'(sfr_i.wdata[`MODE_MD_MSB:`MODE_MD_LSB]);
  assign pri_en = mode_reg[`MODE_PRI_EN_BIT];
  assign aux_en = mode_reg[`MODE_AUX_EN_BIT];
  assign new_pri_en = sfr_i.wdata[`MODE_PRI_EN_BIT];
  assign new_aux_en = sfr_i.wdata[`MODE_AUX_EN_BIT];
  assign md_changed = wr_mode && (new_md != md);
  assign pri_rise = wr_mode && new_pri_en && !pri_en;
  assign aux_rise = wr_mode && new_aux_en && !aux_en;
  assign aux_only_mode_wr = aux_rise && !md_changed && !pri_rise;
  assign both_reset_req = md_changed || (wr_mode && !aux_only_mode_wr)
    || (wr_pri_cfg && pri_en) || pri_rise;
  assign aux_reset_req = wr_aux_cfg || aux_only_mode_wr;
  assign cal_code_wr = wr_mode && new_md[`MODE_MD_MSB];

  // Conversion progress
  assign running = (state == ST_CONVERTING) || (state == ST_CALIBRATING);
  assign is_cal = (state == ST_CALIBRATING);
  assign pri_running = running && pri_en;
  assign aux_on_temp =
    (aux_cfg[`CFG_CH_MSB:`CFG_CH_LSB] == `TEMP_SENSOR_CH);
  assign pri_acc = pri_running && done_i.pri && (pend_pri || !is_cal);
  assign aux_acc = running && aux_en && (pend_aux || !is_cal)
    && (pri_running ? (done_i.pri && (aux_seen || done_i.aux)
    && (align_cnt <= 2'h1)) : done_i.aux);
  assign seq_finish = ((state == ST_CONVERTING && md == MODE_SINGLE)
    || is_cal) && (pend_pri || pend_aux)
    && (!pend_pri || pri_acc) && (!pend_aux || aux_acc);

  // Calibration input source
  always_comb
  begin
    case (md)
      MODE_ZERO_CAL_INT: cal_src = SRC_SHORT;
      MODE_FULL_CAL_INT: cal_src = SRC_REFERENCE;
      default: cal_src = SRC_PINS;
    endcase
  end

  // Sequencer state from the mode field
  always_comb
  begin
    next_state = state;
    case (state)
      ST_STOPPED, ST_WAITING:
        next_state = state;
      ST_CONVERTING, ST_CALIBRATING:
        if (seq_finish)
          next_state = ST_STOPPED;
      default:
        next_state = ST_STOPPED;
    endcase
    if (restart || (aux_restart && state == ST_STOPPED))
    begin
      if (md == MODE_POWER_DOWN || !(pri_en || aux_en))
        next_state = ST_STOPPED;
      else if (md == MODE_IDLE)
        next_state = ST_WAITING;
      else if (md[`MODE_MD_MSB])
        next_state = ST_CALIBRATING;
      else
        next_state = ST_CONVERTING;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      state <= ST_STOPPED;
    else
      state <= next_state;
  end

  // Restart pulses taking effect once the new register values stand
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      restart <= 1'b0;
      aux_restart <= 1'b0;
    end
    else
    begin
      restart <= both_reset_req;
      aux_restart <= aux_reset_req && !both_reset_req;
    end
  end

  // Pending results of the current pass
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pend_pri <= 1'b0;
      pend_aux <= 1'b0;
    end
    else if (restart)
    begin
      pend_pri <= pri_en && md[`MODE_MD_MSB:1] != 2'h0;
      pend_aux <= aux_en && md[`MODE_MD_MSB:1] != 2'h0;
    end
    else
    begin
      if (pri_acc)
        pend_pri <= 1'b0;
      if (aux_restart)
        pend_aux <= aux_en && md[`MODE_MD_MSB:1] != 2'h0;
      else if (aux_acc)
        pend_aux <= 1'b0;
    end
  end

  // Auxiliary alignment to the primary output cadence
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || restart)
    begin
      aux_seen <= 1'b0;
      align_cnt <= 2'h0;
    end
    else if (aux_restart)
    begin
      aux_seen <= 1'b0;
      align_cnt <= pri_running ? `AUX_ALIGN_OUTPUTS : 2'h0;
    end
    else
    begin
      if (aux_acc)
        aux_seen <= 1'b0;
      else if (done_i.aux)
        aux_seen <= 1'b1;
      if (pri_running && done_i.pri && align_cnt != 2'h0)
        align_cnt <= align_cnt - 2'h1;
    end
  end

  // Mode register
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      mode_reg <= `MODE_RESET;
    else if (wr_mode)
      mode_reg <= sfr_i.wdata & `MODE_MASK;
    else if (seq_finish)
      mode_reg[`MODE_MD_MSB:`MODE_MD_LSB] <= MODE_POWER_DOWN;
  end

  // Converter configuration and filter rate
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pri_cfg <= `PRI_CFG_RESET;
      aux_cfg <= `AUX_CFG_RESET;
      filter_rate <= `FILTER_RESET;
    end
    else
    begin
      if (wr_pri_cfg)
        pri_cfg <= sfr_i.wdata & `PRI_CFG_MASK;
      if (wr_aux_cfg)
        aux_cfg <= sfr_i.wdata & `AUX_CFG_MASK;
      if (wr_filter)
        filter_rate <= sfr_i.wdata;
    end
  end

  // Status flags; hardware set wins over any clear
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      primary_ready_flag <= 1'b0;
      auxiliary_ready_flag <= 1'b0;
      auxiliary_error_flag <= 1'b0;
    end
    else
    begin
      if (pri_acc)
        primary_ready_flag <= 1'b1;
      else if (cal_code_wr)
        primary_ready_flag <= 1'b0;
      else if (wr_status && !sfr_i.wdata[`STAT_PRIMARY_READY_FLAG_BIT])
        primary_ready_flag <= 1'b0;
      if (aux_acc)
        auxiliary_ready_flag <= 1'b1;
      else if (cal_code_wr)
        auxiliary_ready_flag <= 1'b0;
      else if (wr_status && !sfr_i.wdata[`STAT_AUXILIARY_READY_FLAG_BIT])
        auxiliary_ready_flag <= 1'b0;
      if (aux_acc && is_cal && aux_on_temp)
        auxiliary_error_flag <= 1'b1;
      else if (wr_status && !sfr_i.wdata[`STAT_AUXILIARY_ERROR_FLAG_BIT])
        auxiliary_error_flag <= 1'b0;
    end
  end

  // Read data
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      sfr_rdata_o <= 8'h00;
    else if (!sfr_i.rd)
      sfr_rdata_o <= sfr_rdata_o;
    else if (sfr_i.addr == `MODE_ADDR)
      sfr_rdata_o <= mode_reg;
    else if (sfr_i.addr == `PRI_CFG_ADDR)
      sfr_rdata_o <= pri_cfg;
    else if (sfr_i.addr == `AUX_CFG_ADDR)
      sfr_rdata_o <= aux_cfg;
    else if (sfr_i.addr == `STATUS_ADDR)
    begin
      sfr_rdata_o <= 8'h00;
      sfr_rdata_o[`STAT_PRIMARY_READY_FLAG_BIT] <= primary_ready_flag;
      sfr_rdata_o[`STAT_AUXILIARY_READY_FLAG_BIT] <= auxiliary_ready_flag;
      sfr_rdata_o[`STAT_AUXILIARY_ERROR_FLAG_BIT] <= auxiliary_error_flag;
    end
    else if (sfr_i.addr == `FILTER_ADDR)
      sfr_rdata_o <= filter_rate;
    else
      sfr_rdata_o <= 8'h00;
  end

  // Primary converter controls
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      pri_ctrl_o <= '0;
    else
    begin
      pri_ctrl_o.reset <= both_reset_req;
      pri_ctrl_o.hold <= pri_en && md == MODE_IDLE;
      pri_ctrl_o.powered <= pri_en && md != MODE_POWER_DOWN;
      pri_ctrl_o.mode <= pri_en ? md : MODE_POWER_DOWN;
      pri_ctrl_o.src <= md[`MODE_MD_MSB] ? cal_src : SRC_PINS;
      pri_ctrl_o.ext_ref <= pri_cfg[`CFG_REF_BIT];
      pri_ctrl_o.channel <= pri_cfg[`CFG_CH_MSB:`CFG_CH_LSB];
      pri_ctrl_o.coef_wr <= pri_acc && is_cal;
      pri_ctrl_o.result_wr <= pri_acc && !is_cal;
    end
  end

  // Auxiliary converter controls
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      aux_ctrl_o <= '0;
    else
    begin
      aux_ctrl_o.reset <= both_reset_req || aux_reset_req;
      aux_ctrl_o.hold <= aux_en && md == MODE_IDLE;
      aux_ctrl_o.powered <= aux_en && md != MODE_POWER_DOWN;
      aux_ctrl_o.mode <= aux_en ? md : MODE_POWER_DOWN;
      aux_ctrl_o.src <= md[`MODE_MD_MSB] ? cal_src : SRC_PINS;
      aux_ctrl_o.ext_ref <= aux_cfg[`CFG_REF_BIT];
      aux_ctrl_o.channel <= aux_cfg[`CFG_CH_MSB:`CFG_CH_LSB];
      aux_ctrl_o.coef_wr <= aux_acc && is_cal && !aux_on_temp;
      aux_ctrl_o.result_wr <= aux_acc && !is_cal;
    end
  end

  // Filter rate seen by the converters
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      filter_rate_o <= `FILTER_RESET;
    else if (next_state == ST_CALIBRATING)
      filter_rate_o <= `FILTER_MAX;
    else
      filter_rate_o <= filter_rate;
  end

endmodule

`default_nettype wire

// ==== design/adc_seq_regs.svh ====
// Purpose: Offsets, field positions, reset values and counts of the
//          converter mode sequencer.
// Assumes: Included by bare name; definitions only.
// Notes: Status and filter-rate offsets and status bit positions are local.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define MODE_ADDR 8'hD1
`define PRI_CFG_ADDR 8'hD2
`define AUX_CFG_ADDR 8'hD3
`define STATUS_ADDR 8'hD4
`define FILTER_ADDR 8'hD5

`define MODE_RESET 8'h00
`define PRI_CFG_RESET 8'h07
`define AUX_CFG_RESET 8'h00
`define FILTER_RESET 8'h45

`define MODE_MASK 8'h37
`define PRI_CFG_MASK 8'h7F
`define AUX_CFG_MASK 8'h78
`define MODE_PRI_EN_BIT 5
`define MODE_AUX_EN_BIT 4
`define MODE_MD_MSB 2
`define MODE_MD_LSB 0
`define CFG_REF_BIT 6
`define CFG_CH_MSB 5
`define CFG_CH_LSB 4
`define STAT_PRIMARY_READY_FLAG_BIT 7
`define STAT_AUXILIARY_READY_FLAG_BIT 6
`define STAT_AUXILIARY_ERROR_FLAG_BIT 5

`define FILTER_MAX 8'hFF
`define AUX_ALIGN_OUTPUTS 2'h3
`define TEMP_SENSOR_CH 2'h2

`endif

// ==== design/adc_seq_pkg.sv ====
// Purpose: Types shared by the converter mode sequencer and its bench.
// Assumes: Nothing beyond this file.
// Notes: Mode codes follow the shared three-bit mode field.
package adc_seq_pkg;

  typedef enum logic [2:0] {
    MODE_POWER_DOWN = 3'h0,
    MODE_IDLE = 3'h1,
    MODE_SINGLE = 3'h2,
    MODE_CONTINUOUS = 3'h3,
    MODE_ZERO_CAL_INT = 3'h4,
    MODE_FULL_CAL_INT = 3'h5,
    MODE_ZERO_CAL_SYS = 3'h6,
    MODE_FULL_CAL_SYS = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    SRC_PINS = 2'h0,
    SRC_SHORT = 2'h1,
    SRC_REFERENCE = 2'h2
  } input_src_t;

  typedef enum logic [3:0] {
    ST_STOPPED = 4'h1,
    ST_WAITING = 4'h2,
    ST_CONVERTING = 4'h4,
    ST_CALIBRATING = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_bus_t;

  typedef struct packed {
    logic pri;
    logic aux;
  } conv_done_t;

  typedef struct packed {
    logic reset;
    logic hold;
    logic powered;
    mode_t mode;
    input_src_t src;
    logic ext_ref;
    logic [1:0] channel;
    logic coef_wr;
    logic result_wr;
  } conv_ctrl_t;

endpackage

// ==== sim/dual_adc_mode_sequencer_sva.sv ====
// Purpose: Port checks of the converter mode sequencer
// Assumes: Bound to the design top
// Notes: Control levels lag the registers by one cycle
`timescale 1ns/10ps
`default_nettype none
module dual_adc_mode_sequencer_sva
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire adc_seq_pkg::sfr_bus_t sfr_i,
  input wire adc_seq_pkg::conv_done_t done_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire adc_seq_pkg::conv_ctrl_t pri_ctrl_o,
  input wire adc_seq_pkg::conv_ctrl_t aux_ctrl_o,
  input wire logic [7:0] filter_rate_o
);
  import adc_seq_pkg::*;
  wire logic mw = sfr_i.wr && sfr_i.addr == 8'hD1;
  wire logic pw = pri_ctrl_o.powered;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  mode_rst_a:
    assert property (mw && sfr_i.wdata[5:4] == 2'h0
      |=> pri_ctrl_o.reset && aux_ctrl_o.reset) else $error("mode reset");
  pri_cfg_rst_a:
    assert property (sfr_i.wr && sfr_i.addr == 8'hD2 && pw && !$past(sfr_i.wr)
      |=> pri_ctrl_o.reset && aux_ctrl_o.reset) else $error("cfg reset");
  aux_rst_a:
    assert property (sfr_i.wr && sfr_i.addr == 8'hD3
      |=> aux_ctrl_o.reset && !pri_ctrl_o.reset) else $error("aux reset");
  rsvd_bit_a:
    assert property (sfr_i.rd && sfr_i.addr == 8'hD2 |=> !sfr_rdata_o[7])
      else $error("reserved bit");
  cal_rate_a:
    assert property (mw && sfr_i.wdata[2] && sfr_i.wdata[5]
      |-> ##[1:3] filter_rate_o == 8'hFF) else $error("cal rate");
  cont_res_a:
    assert property (pw && pri_ctrl_o.mode == MODE_CONTINUOUS && done_i.pri
      && !sfr_i.wr && !pri_ctrl_o.reset |=> pri_ctrl_o.result_wr)
      else $error("no result");
  single_end_a:
    assert property (pri_ctrl_o.result_wr && !aux_ctrl_o.powered
      && $past(pri_ctrl_o.mode) == MODE_SINGLE
      |-> ##[0:1] pri_ctrl_o.mode == MODE_POWER_DOWN) else $error("single");
  cal_end_a:
    assert property (pri_ctrl_o.coef_wr && !aux_ctrl_o.powered
      |-> ##[0:1] pri_ctrl_o.mode == MODE_POWER_DOWN) else $error("cal end");
  cal_src_a:
    assert property (pw && pri_ctrl_o.mode[2] && $stable(pri_ctrl_o.mode)
      |-> pri_ctrl_o.src == (pri_ctrl_o.mode[1] ? SRC_PINS :
      pri_ctrl_o.mode[0] ? SRC_REFERENCE : SRC_SHORT)) else $error("source");
  temp_cal_a:
    assert property (aux_ctrl_o.coef_wr |-> aux_ctrl_o.channel != 2'h2)
      else $error("temp cal");
  cover property (pri_ctrl_o.coef_wr);
  cover property (aux_ctrl_o.reset && !pri_ctrl_o.reset);
  cover property (pri_ctrl_o.hold);
endmodule
bind dual_adc_mode_sequencer dual_adc_mode_sequencer_sva chk_u (
  .mclk_i(mclk_i), .reset_i(reset_i), .sfr_i(sfr_i), .done_i(done_i),
  .sfr_rdata_o(sfr_rdata_o), .pri_ctrl_o(pri_ctrl_o),
  .aux_ctrl_o(aux_ctrl_o), .filter_rate_o(filter_rate_o));
`default_nettype wire

// ==== sim/conv_model.sv ====
// Purpose: Converter pair answering with output pulses
// Assumes: Auxiliary runs three cycles slower than primary
// Notes: Counts restart on reset, hold or power-down
`timescale 1ns/10ps
`default_nettype none
module conv_model
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire adc_seq_pkg::conv_ctrl_t pri_i,
  input wire adc_seq_pkg::conv_ctrl_t aux_i,
  input wire logic [7:0] period_i,
  output var adc_seq_pkg::conv_done_t done_o
);
  import adc_seq_pkg::*;
  logic [7:0] pcnt;
  logic [7:0] acnt;
  wire logic prun = pri_i.powered && !pri_i.hold;
  wire logic arun = aux_i.powered && !aux_i.hold;
  assign done_o.pri = prun && pcnt == period_i;
  assign done_o.aux = arun && acnt == period_i + 8'h03;
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || pri_i.reset || !prun || done_o.pri)
      pcnt <= 8'h00;
    else
      pcnt <= pcnt + 8'h01;
  end
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || aux_i.reset || !arun || done_o.aux)
      acnt <= 8'h00;
    else
      acnt <= acnt + 8'h01;
  end
endmodule
`default_nettype wire

// ==== sim/dual_adc_mode_sequencer_tb.sv ====
// Purpose: Self-checking bench of the converter mode sequencer
// Assumes: Reads checked by a queue watcher
// Notes: Converter period is random
`timescale 1ns/10ps
`default_nettype none
module dual_adc_mode_sequencer_tb;
  import adc_seq_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  sfr_bus_t sfr_i = '0;
  conv_done_t done_i;
  logic [7:0] sfr_rdata_o;
  logic [7:0] filter_rate_o;
  conv_ctrl_t pri_ctrl_o;
  conv_ctrl_t aux_ctrl_o;
  logic [7:0] period = 8'h06;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  dual_adc_mode_sequencer dut (.mclk_i(mclk_i), .reset_i(reset_i),
    .sfr_i(sfr_i), .done_i(done_i), .sfr_rdata_o(sfr_rdata_o),
    .pri_ctrl_o(pri_ctrl_o), .aux_ctrl_o(aux_ctrl_o),
    .filter_rate_o(filter_rate_o));
  conv_model far (.mclk_i(mclk_i), .reset_i(reset_i), .pri_i(pri_ctrl_o),
    .aux_i(aux_ctrl_o), .period_i(period), .done_o(done_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d,
    input logic w);
    @(posedge mclk_i);
    #1 sfr_i = '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w)
      exp_q.push_back(d);
    @(posedge mclk_i);
    #1 sfr_i = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(a, e, 1'b0);
  endtask
  task automatic wait_pd();
    int i;
    repeat (2) @(posedge mclk_i);
    #1 i = 0;
    while (pri_ctrl_o.mode !== MODE_POWER_DOWN && i < 400)
    begin
      @(posedge mclk_i);
      #1 i++;
    end
    chk(8'(i < 400), 8'h01);
  endtask
  always @(posedge mclk_i)
  begin
    if (rd_seen)
      chk(sfr_rdata_o, exp_q.pop_front());
    rd_seen <= sfr_i.rd;
  end
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    logic [7:0] cfg;
    logic [7:0] en;
    logic [7:0] acfg;
    int n;
    void'($urandom(17));
    period = 8'($urandom_range(12, 6));
    repeat (2) @(posedge mclk_i);
    #1 reset_i = 1'b0;
    rd(8'hD1, 8'h00);
    rd(8'hD2, 8'h07);
    rd(8'hD3, 8'h00);
    rd(8'hD5, 8'h45);
    rd(8'hD0, 8'h00);
    wr(8'hD2, 8'hFF);
    rd(8'hD2, 8'h7F);
    wr(8'hD1, 8'h22);
    wait_pd();
    rd(8'hD1, 8'h20);
    rd(8'hD4, 8'h80);
    for (int c = 4; c < 8; c++)
    begin
      en = (c < 6) ? 8'h30 : 8'h20;
      cfg = 8'($urandom) & 8'h7F;
      wr(8'hD2, cfg);
      acfg = 8'($urandom) & 8'h40;
      wr(8'hD3, acfg);
      wr(8'hD1, en | 8'(c));
      rd(8'hD4, 8'h00);
      @(posedge mclk_i);
      #1 chk(filter_rate_o, 8'hFF);
      chk(8'(pri_ctrl_o.src), 8'(c == 4) | 8'(c == 5) << 1);
      chk(8'({pri_ctrl_o.ext_ref, pri_ctrl_o.channel}), 8'(cfg[6:4]));
      chk(8'({aux_ctrl_o.ext_ref, aux_ctrl_o.channel}), 8'(acfg[6:4]));
      wait_pd();
      rd(8'hD1, en);
      rd(8'hD4, en << 2);
    end
    wr(8'hD3, 8'h20);
    wr(8'hD1, 8'h34);
    wait_pd();
    rd(8'hD4, 8'hE0);
    wr(8'hD4, 8'h00);
    rd(8'hD4, 8'h00);
    wr(8'hD3, 8'h00);
    wr(8'hD1, 8'h31);
    @(posedge mclk_i);
    #1 chk(8'({pri_ctrl_o.hold, aux_ctrl_o.hold}), 8'h03);
    cfg = 8'($urandom);
    wr(8'hD5, cfg);
    rd(8'hD5, cfg);
    wr(8'hD1, 8'h23);
    chk(filter_rate_o, cfg);
    n = 0;
    repeat (80)
    begin
      @(posedge mclk_i);
      #1 if (pri_ctrl_o.result_wr === 1'b1)
        n++;
    end
    chk(8'(n >= 80 / (period + 1) - 2), 8'h01);
    wr(8'hD1, 8'h33);
    chk(8'({pri_ctrl_o.reset, aux_ctrl_o.reset}), 8'h01);
    n = 0;
    en = 8'h00;
    @(posedge mclk_i);
    repeat (200)
    begin
      @(posedge mclk_i);
      #1 if (pri_ctrl_o.result_wr === 1'b1 && en == 8'h00)
        n++;
      if (aux_ctrl_o.result_wr === 1'b1)
        en = 8'h01;
    end
    chk(8'(n >= 1 && n <= 3 && en == 8'h01), 8'h01);
    wr(8'hD2, 8'h07);
    chk(8'({pri_ctrl_o.reset, aux_ctrl_o.reset}), 8'h03);
    wr(8'hD1, 8'h00);
    @(posedge mclk_i);
    #1 chk(8'({pri_ctrl_o.powered, aux_ctrl_o.powered}), 8'h00);
    repeat (3) @(posedge mclk_i);
    tally_and_finish();
  end
endmodule
`default_nettype wire
